// *** include/pmw_pkg.sv ***
// Package for the power mode and wake control block.
// Assumes a single 250 MHz system clock and an APB register port.
`default_nettype none
package pmw_pkg;
  // ==========================================================================
  // Register map (byte addresses).
  localparam logic [11:0] MODE_OFF   = 12'h000;
  localparam logic [11:0] CTRL_OFF   = 12'h004;
  localparam logic [11:0] WAKE_OFF   = 12'h008;
  localparam logic [11:0] STAT_OFF   = 12'h00C;
  localparam logic [11:0] INTP_OFF   = 12'h010;
  // ==========================================================================
  // Mode register fields and reset values.
  localparam int          DIV_LSB    = 5;
  localparam int          IDLE_BIT   = 1;
  localparam int          HCLK_BIT   = 0;
  localparam logic [7:0]  MODE_RST   = 8'h01;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  WAKE_RST   = 8'h00;
  // Port pins idle high; the edge register starts there so reset is no edge.
  localparam logic [7:0]  PORTA_RST  = 8'hFF;
  // Control register: bit 7 keeps the system clock in idle, bit 0 enables
  // the watchdog, bit 1 enables the voltage detector, bit 2 selects crystals.
  localparam int          SYSON_BIT  = 7;
  localparam int          WDTEN_BIT  = 0;
  localparam int          LVDEN_BIT  = 1;
  localparam int          XTAL_BIT   = 2;
  // ==========================================================================
  // Oscillator start-up counts in oscillator cycles, here counted as
  // cycles of the enable pulses of the respective oscillator.
  localparam logic [9:0]  HXT_START  = 10'h200;
  localparam logic [9:0]  HIGH_SPEED_INTERNAL_OSC_START = 10'h010;
  localparam logic [9:0]  LXT_START  = 10'h080;
  localparam logic [9:0]  LOW_SPEED_INTERNAL_OSC_START = 10'h002;
  localparam int          DIV16      = 16;
  localparam int          DIV64      = 64;
  typedef enum logic [2:0] {
    PM_RUN, PM_DEEP, PM_LIGHT, PM_IDLE_OFF, PM_IDLE_ON
  } pmw_state_t;
endpackage
`default_nettype wire

// *** rtl/pmw_top.sv ***
// Power mode and wake control: mode switching, halt states, clock gates,
// power-down and time-out flags, wake-up logic.
// Assumes the core pulses halt and clear-watchdog; oscillators are modelled
// by tick inputs, the watchdog divider by an overflow input.
`default_nettype none
module pmw_top (
  input  wire logic        SYS_CLK,
  input  wire logic        NRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        HALT_REQ,
  input  wire logic        CLR_WDT,
  input  wire logic [7:0]  PORT_A,
  input  wire logic [7:0]  INT_REQ,
  input  wire logic [7:0]  INT_EN,
  input  wire logic        STACK_FULL,
  input  wire logic        WDT_OVF,
  input  wire logic        HOSC_TICK,
  input  wire logic        LOSC_TICK,
  output logic             SYSCLK_EN,
  output logic             TBCLK_EN,
  output logic             SUBCLK_EN,
  output logic             WDTCLK_EN,
  output logic             WDT_CLEAR,
  output logic             HOSC_EN,
  output logic             SYS_SRC_LOW,
  output logic             CPU_HALTED,
  output logic             WAKE_RESUME,
  output logic             WAKE_VECTOR,
  output logic             WAKE_PCSP_RST,
  output logic             POWER_DOWN_FLAG,
  output logic             TIMEOUT_FLAG
);
  // ==========================================================================
  // Registers.
  logic [7:0]  mode_reg;
  logic [7:0]  ctrl_reg;
  logic [7:0]  wake_en_reg;
  logic [7:0]  porta_reg;
  logic [7:0]  int_mask_reg;
  logic [9:0]  hcnt_reg;
  logic [9:0]  lcnt_reg;
  logic        hready_reg;
  logic        lready_reg;
  logic        pdf_reg;
  logic        tof_reg;
  pmw_pkg::pmw_state_t state_reg;

  logic        wr;
  logic        rd;
  logic        low_sel;
  logic        in_halt;
  logic        deep;
  logic        port_wake;
  logic        int_wake;
  logic        wake;
  logic        int_ok;
  logic        xtal;
  logic        wdt_on;
  logic [9:0]  hstart;
  logic [9:0]  lstart;

  assign wr   = PSEL & PENABLE & PWRITE;
  assign rd   = PSEL & PENABLE & ~PWRITE;
  assign xtal = ctrl_reg[pmw_pkg::XTAL_BIT];
  assign wdt_on = ctrl_reg[pmw_pkg::WDTEN_BIT];
  assign hstart = xtal ? pmw_pkg::HXT_START : pmw_pkg::HIGH_SPEED_INTERNAL_OSC_START;
  assign lstart = xtal ? pmw_pkg::LXT_START : pmw_pkg::LOW_SPEED_INTERNAL_OSC_START;
  // Divider 000 or 001 with the high select low picks the low-speed clock.
  assign low_sel = ~mode_reg[pmw_pkg::HCLK_BIT]
                 & (mode_reg[7:6] == 2'b00);
  assign in_halt = (state_reg != pmw_pkg::PM_RUN);
  assign deep    = (state_reg == pmw_pkg::PM_DEEP);

  // ==========================================================================
  // Wake sources.
  // A port pin wakes on a high-to-low step only where its enable is set.
  assign port_wake = |(porta_reg & ~PORT_A & wake_en_reg);
  // Requests already pending at halt entry are masked out of the wake.
  assign int_wake  = |(INT_REQ & ~int_mask_reg);
  assign wake      = in_halt & (port_wake | int_wake | WDT_OVF);
  assign int_ok    = |(INT_REQ & ~int_mask_reg & INT_EN) & ~STACK_FULL;

  // Last pin levels for the falling-edge detector.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      porta_reg <= pmw_pkg::PORTA_RST;
    end else begin
      porta_reg <= PORT_A;
    end
  end

  // ==========================================================================
  // APB slave: zero wait states, unmapped addresses answer with an error.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      mode_reg    <= pmw_pkg::MODE_RST;
      ctrl_reg    <= pmw_pkg::CTRL_RST;
      wake_en_reg <= pmw_pkg::WAKE_RST;
    end else if (wr) begin
      case (PADDR)
        pmw_pkg::MODE_OFF: mode_reg    <= {PWDATA[7:5], 2'b00, PWDATA[2:0] & 3'h3};
        pmw_pkg::CTRL_OFF: ctrl_reg    <= {PWDATA[7], 4'h0, PWDATA[2:0]};
        pmw_pkg::WAKE_OFF: wake_en_reg <= PWDATA[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      if (PSEL & ~PENABLE) begin
        case (PADDR)
          pmw_pkg::MODE_OFF: PRDATA <= {24'h0, mode_reg[7:5], 1'b0, lready_reg,
                                        hready_reg, mode_reg[1:0]};
          pmw_pkg::CTRL_OFF: PRDATA <= {24'h0, ctrl_reg};
          pmw_pkg::WAKE_OFF: PRDATA <= {24'h0, wake_en_reg};
          pmw_pkg::STAT_OFF: PRDATA <= {26'h0, lready_reg, hready_reg, 1'b0,
                                        in_halt, tof_reg, pdf_reg};
          pmw_pkg::INTP_OFF: PRDATA <= {24'h0, int_mask_reg};
          default:           PSLVERR <= 1'b1;
        endcase
      end
    end
  end
  // The answer is given one cycle after setup; rd and wr use the access phase.
  logic unused_rd;
  assign unused_rd = rd;

  // ==========================================================================
  // Halt state machine.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg    <= pmw_pkg::PM_RUN;
      int_mask_reg <= 8'h00;
    end else begin
      case (state_reg)
        pmw_pkg::PM_RUN: begin
          if (HALT_REQ) begin
            int_mask_reg <= INT_REQ;
            if (mode_reg[pmw_pkg::IDLE_BIT]) begin
              state_reg <= ctrl_reg[pmw_pkg::SYSON_BIT] ? pmw_pkg::PM_IDLE_ON
                                                       : pmw_pkg::PM_IDLE_OFF;
            end else if (wdt_on) begin
              state_reg <= pmw_pkg::PM_LIGHT;
            end else if (!ctrl_reg[pmw_pkg::LVDEN_BIT]) begin
              state_reg <= pmw_pkg::PM_DEEP;
            end else begin
              state_reg <= pmw_pkg::PM_LIGHT;
            end
          end
        end
        default: begin
          // Masked requests stay pending; clearing them frees the mask bit.
          int_mask_reg <= int_mask_reg & INT_REQ;
          if (wake) begin
            state_reg <= pmw_pkg::PM_RUN;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Flags: halt sets power-down and clears time-out; overflow wake sets it.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      pdf_reg         <= 1'b0;
      tof_reg         <= 1'b0;
      POWER_DOWN_FLAG <= 1'b0;
      TIMEOUT_FLAG    <= 1'b0;
    end else begin
      if (HALT_REQ && !in_halt) begin
        pdf_reg         <= 1'b1;
        tof_reg         <= 1'b0;
        POWER_DOWN_FLAG <= 1'b1;
        TIMEOUT_FLAG    <= 1'b0;
      end else begin
        if (CLR_WDT) begin
          pdf_reg         <= 1'b0;
          POWER_DOWN_FLAG <= 1'b0;
        end
        if (wake && WDT_OVF) begin
          tof_reg      <= 1'b1;
          TIMEOUT_FLAG <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Oscillator ready counters, restarted from zero while the oscillator is off.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      hcnt_reg   <= 10'h000;
      hready_reg <= 1'b0;
      lcnt_reg   <= 10'h000;
      lready_reg <= 1'b0;
    end else begin
      if (!HOSC_EN) begin
        hcnt_reg   <= 10'h000;
        hready_reg <= 1'b0;
      end else if (!hready_reg && HOSC_TICK) begin
        hcnt_reg <= hcnt_reg + 10'h001;
        if (hcnt_reg + 10'h001 >= hstart) begin
          hready_reg <= 1'b1;
        end
      end
      if (!SUBCLK_EN) begin
        lcnt_reg   <= 10'h000;
        lready_reg <= 1'b0;
      end else if (!lready_reg && LOSC_TICK) begin
        lcnt_reg <= lcnt_reg + 10'h001;
        if (lcnt_reg + 10'h001 >= lstart) begin
          lready_reg <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Clock gates and wake pulses; all registered outputs.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      SYSCLK_EN     <= 1'b1;
      TBCLK_EN      <= 1'b1;
      SUBCLK_EN     <= 1'b1;
      WDTCLK_EN     <= 1'b1;
      WDT_CLEAR     <= 1'b0;
      HOSC_EN       <= 1'b1;
      SYS_SRC_LOW   <= 1'b0;
      CPU_HALTED    <= 1'b0;
      WAKE_RESUME   <= 1'b0;
      WAKE_VECTOR   <= 1'b0;
      WAKE_PCSP_RST <= 1'b0;
    end else begin
      // Memory, registers and ports are never touched here; only gating.
      CPU_HALTED <= in_halt & ~wake;
      SYSCLK_EN  <= ~in_halt | wake | (state_reg == pmw_pkg::PM_IDLE_ON);
      TBCLK_EN   <= ~in_halt | wake | (state_reg == pmw_pkg::PM_IDLE_ON)
                  | (state_reg == pmw_pkg::PM_IDLE_OFF);
      SUBCLK_EN  <= ~deep | wake;
      WDTCLK_EN  <= (~deep | wake) & wdt_on;
      WDT_CLEAR  <= HALT_REQ & ~in_halt;
      // Only after low-ready does the system leave the high clock.
      SYS_SRC_LOW <= low_sel & lready_reg;
      HOSC_EN    <= ~(low_sel & lready_reg) & ~(in_halt & ~wake
                  & (state_reg != pmw_pkg::PM_IDLE_ON));
      WAKE_RESUME   <= wake & ~WDT_OVF & ~int_ok;
      WAKE_VECTOR   <= wake & ~WDT_OVF & ~port_wake & int_ok;
      WAKE_PCSP_RST <= wake & WDT_OVF;
    end
  end
endmodule
`default_nettype wire

// *** bench/pmw_props.sv ***
// Checker for the power mode and wake control block.
// Sees only the top module ports; bound to pmw_top below.
`default_nettype none
module pmw_props (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic HALT_REQ,
  input wire logic WDT_OVF,
  input wire logic SYSCLK_EN,
  input wire logic TBCLK_EN,
  input wire logic SUBCLK_EN,
  input wire logic WDT_CLEAR,
  input wire logic HOSC_EN,
  input wire logic SYS_SRC_LOW,
  input wire logic CPU_HALTED,
  input wire logic WAKE_RESUME,
  input wire logic WAKE_VECTOR,
  input wire logic WAKE_PCSP_RST
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // ==========================================================================
  // Halt entry, sleep states and slow mode.
  property p_halt_clr; HALT_REQ |-> ##[1:2] WDT_CLEAR; endproperty
  a_halt_clr: assert property (p_halt_clr) else $error("no watchdog clear on halt");
  property p_halt_stop; HALT_REQ |-> ##[1:2] CPU_HALTED; endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("halt not entered");
  property p_sleep; CPU_HALTED && !TBCLK_EN |-> !SYSCLK_EN; endproperty
  a_sleep: assert property (p_sleep) else $error("system clock on in sleep");
  property p_idle_clock_on_state; CPU_HALTED && SYSCLK_EN |-> TBCLK_EN && SUBCLK_EN; endproperty
  a_idle_clock_on_state: assert property (p_idle_clock_on_state) else $error("idle clocks stopped");
  property p_slow; SYS_SRC_LOW |-> ##[0:2] !HOSC_EN; endproperty
  a_slow: assert property (p_slow) else $error("high oscillator on in slow mode");
  // ==========================================================================
  // Wake-up and register port.
  property p_pcsp; WDT_OVF && CPU_HALTED |-> ##[1:3] WAKE_PCSP_RST; endproperty
  a_pcsp: assert property (p_pcsp) else $error("overflow wake missing");
  property p_excl; WAKE_VECTOR |-> !WAKE_RESUME; endproperty
  a_excl: assert property (p_excl) else $error("vector and resume together");
  property p_rel; WAKE_RESUME || WAKE_VECTOR || WAKE_PCSP_RST |-> ##[0:2] !CPU_HALTED;
  endproperty
  a_rel: assert property (p_rel) else $error("core not released on wake");
  property p_ans; PSEL && PENABLE |-> PREADY && $past(PSEL); endproperty
  a_ans: assert property (p_ans) else $error("access without ready");
  c_sleep: cover property (CPU_HALTED && !TBCLK_EN);
  c_vec: cover property (WAKE_VECTOR);
  c_pcsp: cover property (WAKE_PCSP_RST);
endmodule
bind pmw_top pmw_props u_props (.*);
`default_nettype wire

// *** bench/pmw_core_model.sv ***
// Processor core model issuing halt and clear-watchdog instruction pulses.
// Assumes the bench raises one-cycle requests on its own clock.
`default_nettype none
module pmw_core_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic go_halt,
  input  wire logic go_clr,
  input  wire logic halted,
  output logic      halt_req,
  output logic      clr_wdt
);
  timeunit 1ns;
  timeprecision 1ps;
  // A stopped core executes nothing, so requests while halted are dropped.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      halt_req <= 1'b0;
      clr_wdt  <= 1'b0;
    end else begin
      halt_req <= go_halt && !halted;
      clr_wdt  <= go_clr && !halted;
    end
  end
endmodule
`default_nettype wire

// *** bench/tb_power_mode_wake_control.sv ***
// Testbench for pmw_top: APB register access, mode switching, halt and wake.
// Assumes the core model drives halt and clear-watchdog pulses.
`default_nettype none
module tb_power_mode_wake_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        SYS_CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
  logic        HALT_REQ, CLR_WDT, STACK_FULL, WDT_OVF, HOSC_TICK, LOSC_TICK;
  logic        SYSCLK_EN, TBCLK_EN, SUBCLK_EN, WDTCLK_EN, WDT_CLEAR, HOSC_EN;
  logic        SYS_SRC_LOW, CPU_HALTED, WAKE_RESUME, WAKE_VECTOR, WAKE_PCSP_RST;
  logic        POWER_DOWN_FLAG, TIMEOUT_FLAG, go_halt, go_clr;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  logic [7:0]  PORT_A, INT_REQ, INT_EN;
  logic [2:0]  tick;
  logic [2:0]  ex [4] = '{3'b000, 3'b001, 3'b010, 3'b110};
  logic [7:0]  ctl [4] = '{8'h00, 8'h01, 8'h00, 8'h80};
  logic [7:0]  mde [4] = '{8'h01, 8'h01, 8'h03, 8'h03};
  int          n_errors, num_checks, n_res, n_vec, n_pc, r0, v0, p0, n;
  pmw_top dut_u (.*);
  pmw_core_model core_u (.clk(SYS_CLK), .nrst(NRST), .go_halt(go_halt), .go_clr(go_clr),
    .halted(CPU_HALTED), .halt_req(HALT_REQ), .clr_wdt(CLR_WDT));
  initial begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  // Oscillator ticks: the low one is deliberately slow so ready counts take time.
  always @(posedge SYS_CLK) begin
    tick      <= tick + 3'h1;
    HOSC_TICK <= ~HOSC_TICK;
    LOSC_TICK <= (tick == 3'h7);
    n_res     <= n_res + int'(WAKE_RESUME);
    n_vec     <= n_vec + int'(WAKE_VECTOR);
    n_pc      <= n_pc + int'(WAKE_PCSP_RST);
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge SYS_CLK);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1 && k++ < 50);
    q = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic core(input logic h);
    if (h) go_halt <= 1'b1;
    else go_clr <= 1'b1;
    @(posedge SYS_CLK);
    go_halt <= 1'b0;
    go_clr  <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
  endtask
  task automatic wait_run();
    for (int k = 0; k < 50 && CPU_HALTED !== 1'b0; k++) @(posedge SYS_CLK);
    repeat (2) @(posedge SYS_CLK);
    chk("halted", CPU_HALTED, 1'b0);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    {NRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA, STACK_FULL, WDT_OVF} = '0;
    {HOSC_TICK, LOSC_TICK, tick, go_halt, go_clr, INT_REQ} = '0;
    {n_res, n_vec, n_pc} = '0;
    PORT_A = 8'hFF;
    INT_EN = 8'h01;
    repeat (5) @(posedge SYS_CLK);
    NRST <= 1'b1;
    apb(1'b0, pmw_pkg::MODE_OFF, 32'h0);
    chk("mode", q & 32'hF3, {24'h0, pmw_pkg::MODE_RST});
    apb(1'b0, pmw_pkg::CTRL_OFF, 32'h0);
    chk("ctrl", q, {24'h0, pmw_pkg::CTRL_RST});
    apb(1'b0, 12'h020, 32'h0);
    chk("slverr", err, 1'b1);
    for (int d = 0; d < 8; d++) begin
      apb(1'b1, pmw_pkg::MODE_OFF, 32'(d) << pmw_pkg::DIV_LSB);
      repeat (60) @(posedge SYS_CLK);
      chk("src_low", SYS_SRC_LOW, d < 2);
      chk("hosc_en", HOSC_EN, d >= 2);
    end
    n = 0;
    do apb(1'b0, pmw_pkg::STAT_OFF, 32'h0); while (q[4] !== 1'b1 && n++ < 100);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, pmw_pkg::WAKE_OFF, 32'h01);
      apb(1'b1, pmw_pkg::CTRL_OFF, {24'h0, ctl[i]});
      apb(1'b1, pmw_pkg::MODE_OFF, {24'h0, mde[i]});
      {r0, v0, p0} = {n_res, n_vec, n_pc};
      core(1'b1);
      chk("sysclk", SYSCLK_EN, ex[i][2]);
      chk("tbclk", TBCLK_EN, ex[i][1]);
      if (i < 2) chk("wdtclk", WDTCLK_EN, ex[i][0]);
      apb(1'b0, pmw_pkg::STAT_OFF, 32'h0);
      chk("stat", q[1:0], 2'b01);
      chk("pdf_out", POWER_DOWN_FLAG, 1'b1);
      case (i)
        0: PORT_A <= 8'hFE;
        1: WDT_OVF <= 1'b1;
        2: INT_REQ <= 8'h01;
        default: INT_REQ <= 8'h02;
      endcase
      @(posedge SYS_CLK) WDT_OVF <= 1'b0;
      wait_run();
      chk("resume", n_res - r0, i == 0 || i == 3);
      chk("vector", n_vec - v0, i == 2);
      chk("pcsp", n_pc - p0, i == 1);
      apb(1'b0, pmw_pkg::STAT_OFF, 32'h0);
      chk("timeout", q[1], i == 1);
      chk("tof_out", TIMEOUT_FLAG, i == 1);
      PORT_A  <= 8'hFF;
      INT_REQ <= 8'h00;
    end
    INT_REQ <= 8'h04;
    INT_EN  <= 8'h05;
    core(1'b1);
    PORT_A <= 8'hFD;
    repeat (10) @(posedge SYS_CLK);
    chk("pending", CPU_HALTED, 1'b1);
    PORT_A <= 8'hFC;
    wait_run();
    core(1'b0);
    apb(1'b0, pmw_pkg::STAT_OFF, 32'h0);
    chk("pdown", q[0], 1'b0);
    chk("pdf_clr", POWER_DOWN_FLAG, 1'b0);
    close_out();
  end
  initial begin
    repeat (40000) @(posedge SYS_CLK);
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire
